/* File: cs3_pkg.sv */
package cs3_pkg;

    // register indices on the slot register port
    localparam logic ADDR_STATUS = 1'h0;
    localparam logic ADDR_CTRL   = 1'h1;

    // supply selection, class per code
    typedef enum logic [1:0] {
        VSEL_OFF = 2'h0,
        VSEL_1V8 = 2'h1,
        VSEL_3V  = 2'h2,
        VSEL_5V  = 2'h3
    } cs3_vsel_type;

    // card clock source selection
    typedef enum logic [2:0] {
        SRC_MASTER    = 3'h0,
        SRC_CONV      = 3'h1,
        SRC_CONV_D2   = 3'h2,
        SRC_CONV_D4   = 3'h3,
        SRC_AUX       = 3'h4,
        SRC_AUX_D2    = 3'h5,
        SRC_MASTER_D2 = 3'h6,
        SRC_MASTER_D4 = 3'h7
    } cs3_src_type;

    // reset and answer-timeout sequence
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'h0,
        SEQ_DELAY = 2'h1,
        SEQ_WAIT  = 2'h2,
        SEQ_DONE  = 2'h3
    } cs3_seq_type;

    // status and voltage configuration register layout
    typedef struct packed {
        logic         irq;
        logic         good;
        logic         atr;
        logic [1:0]   unused;
        logic         verr;
        cs3_vsel_type vsel;
    } cs3_stat_type;

    // clock and reset control register layout
    typedef struct packed {
        logic        art;
        logic        unused;
        logic        reset_ctl;
        logic        level;
        logic        halt;
        cs3_src_type src;
    } cs3_ctrl_type;

    localparam cs3_stat_type STAT_RESET = 8'h00;
    localparam cs3_ctrl_type CTRL_RESET = 8'h08;

    // divider limits for half periods of the card clock
    localparam logic [1:0] DIV1_LIM = 2'h0;
    localparam logic [1:0] DIV2_LIM = 2'h1;
    localparam logic [1:0] DIV4_LIM = 2'h3;

endpackage

/* File: cs3_clkgen.sv */
module cs3_clkgen
    import cs3_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // settings
    input  wire logic             halt_i,
    input  wire logic             level_i,
    input  wire cs3_pkg::cs3_src_type src_i,
    // synchronised source clocks
    input  wire logic             conv_s_i,
    input  wire logic             aux_s_i,
    // card clock
    output logic                  pin_o,
    output logic                  rise_o,
    output logic                  stopped_o
);
    import cs3_pkg::*;

    logic        conv_prev_reg, conv_prev_next;
    logic        aux_prev_reg, aux_prev_next;
    logic [1:0]  cnt_reg, cnt_next;
    cs3_src_type src_reg, src_next;
    logic        pin_reg, pin_next;
    logic        stop_reg, stop_next;
    logic        rise_reg, rise_next;
    logic        base;
    logic [1:0]  lim;
    logic        half_tick;

    // base event and divider per active source
    always_comb
    begin
        conv_prev_next = conv_s_i;
        aux_prev_next  = aux_s_i;
        case (src_reg)
            SRC_MASTER:    begin base = 1'b1; lim = DIV1_LIM; end
            SRC_CONV:      begin base = conv_s_i ^ conv_prev_reg; lim = DIV1_LIM; end
            SRC_CONV_D2:   begin base = conv_s_i ^ conv_prev_reg; lim = DIV2_LIM; end
            SRC_CONV_D4:   begin base = conv_s_i ^ conv_prev_reg; lim = DIV4_LIM; end
            SRC_AUX:       begin base = aux_s_i ^ aux_prev_reg; lim = DIV1_LIM; end
            SRC_AUX_D2:    begin base = aux_s_i ^ aux_prev_reg; lim = DIV2_LIM; end
            SRC_MASTER_D2: begin base = 1'b1; lim = DIV2_LIM; end
            default:       begin base = 1'b1; lim = DIV4_LIM; end
        endcase
        half_tick = base && (cnt_reg == lim);
        cnt_next  = cnt_reg;
        if (base)
        begin
            cnt_next = half_tick ? 2'h0 : cnt_reg + 2'h1;
        end
        // source and stop changes only land on a half-period boundary
        src_next  = half_tick ? src_i : src_reg;
        stop_next = stop_reg;
        pin_next  = pin_reg;
        if (stop_reg)
        begin
            pin_next = level_i;
            if (half_tick && !halt_i)
            begin
                stop_next = 1'b0;
                pin_next  = !level_i;
            end
        end
        else if (half_tick)
        begin
            if (halt_i && (pin_reg == level_i))
                stop_next = 1'b1;
            else
                pin_next = !pin_reg;
        end
        rise_next = pin_next && !pin_reg && !stop_next;
    end

    // register stage
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            conv_prev_reg <= 1'b0;
            aux_prev_reg  <= 1'b0;
            cnt_reg       <= 2'h0;
            src_reg       <= SRC_MASTER;
            pin_reg       <= 1'b0;
            stop_reg      <= 1'b1;
            rise_reg      <= 1'b0;
        end
        else
        begin
            conv_prev_reg <= conv_prev_next;
            aux_prev_reg  <= aux_prev_next;
            cnt_reg       <= cnt_next;
            src_reg       <= src_next;
            pin_reg       <= pin_next;
            stop_reg      <= stop_next;
            rise_reg      <= rise_next;
        end
    end

    assign pin_o     = pin_reg;
    assign rise_o    = rise_reg;
    assign stopped_o = stop_reg;

    property p_stop_level;
        @(posedge clk_i) disable iff (!arst_n_i)
        (stop_reg && $past(stop_reg)) |-> (pin_reg == $past(level_i));
    endproperty
    a_stop_level: assert property (p_stop_level) else $error("stopped clock off level");

    property p_halt_master;
        @(posedge clk_i) disable iff (!arst_n_i)
        (halt_i && (src_reg == SRC_MASTER))[*6] |-> stop_reg;
    endproperty
    a_halt_master: assert property (p_halt_master) else $error("clock did not stop");

endmodule

/* File: cs3_slot3.sv */
module cs3_slot3
    import cs3_pkg::*;
#(
    parameter int ATR_CYCLES = 40000,
    parameter int RST_DELAY  = 400
)(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // register port
    input  wire logic       reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // regulator and mode
    input  wire logic       slot_regulator_in_range_i,
    input  wire logic       slot_two_full_interface_i,
    // external clocks and pins
    input  wire logic       converter_clock_i,
    input  wire logic       auxiliary_clock_input_i,
    input  wire logic       auxiliary_input_pin_i,
    input  wire logic       card_io_line_i,
    // card side
    output logic            card_clock_pin_o,
    output logic            card_reset_pin_o,
    output logic            slot_attention_o
);
    import cs3_pkg::*;

    localparam int CNT_W = $clog2(ATR_CYCLES + 1);

    if (ATR_CYCLES < 2 || RST_DELAY < 1 || RST_DELAY > ATR_CYCLES)
    begin : g_chk
        $error("cs3_slot3: unusable sequence counts");
    end

    // pin synchronisers: range, converter clk, aux clk, aux reset, io
    logic [4:0]   pins;
    logic [4:0]   sync1_reg;
    logic [4:0]   sync2_reg;
    logic         in_range_s, conv_s, aux_clk_s, aux_rst_s, io_s;
    logic         io_prev_reg;

    cs3_stat_type stat_reg, stat_next;
    cs3_ctrl_type ctrl_reg, ctrl_next;
    logic [7:0]   rdata_reg, rdata_next;
    cs3_seq_type  seq_reg, seq_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic         rst_pin_reg, rst_pin_next;
    logic         attn_reg, attn_next;
    logic         atr_ovf;
    logic         card_rise;
    logic         rd_stat;
    logic         wr_stat;
    logic         wr_ctrl;

    assign pins = {card_io_line_i, auxiliary_input_pin_i, auxiliary_clock_input_i,
                   converter_clock_i, slot_regulator_in_range_i};
    assign in_range_s = sync2_reg[0];
    assign conv_s     = sync2_reg[1];
    assign aux_clk_s  = sync2_reg[2];
    assign aux_rst_s  = sync2_reg[3];
    assign io_s       = sync2_reg[4];

    // two-flop synchronisers, one per pin
    for (genvar g = 0; g < 5; g++)
    begin : g_sync
        always_ff @(posedge clk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                sync1_reg[g] <= 1'b0;
                sync2_reg[g] <= 1'b0;
            end
            else
            begin
                sync1_reg[g] <= pins[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end

    // register access decode
    assign rd_stat = reg_rd_i && (reg_addr_i == ADDR_STATUS);
    assign wr_stat = reg_wr_i && (reg_addr_i == ADDR_STATUS);
    assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);

    // register file next values
    always_comb
    begin
        stat_next = stat_reg;
        ctrl_next = ctrl_reg;
        if (rd_stat)
        begin
            stat_next.irq  = 1'b0;
            stat_next.atr  = 1'b0;
            stat_next.verr = 1'b0;
        end
        if (wr_stat)
        begin
            stat_next.vsel = cs3_vsel_type'(reg_wdata_i[1:0]);
            if (reg_wdata_i[5])
                stat_next.atr = 1'b1;
            if (reg_wdata_i[2])
                stat_next.verr = 1'b1;
        end
        // hardware sets win over read clears
        stat_next.good = in_range_s && (stat_reg.vsel != VSEL_OFF);
        if (stat_next.good && !stat_reg.good)
            stat_next.irq = 1'b1;
        if (atr_ovf)
            stat_next.atr = 1'b1;
        if (stat_reg.good && !in_range_s && (stat_reg.vsel != VSEL_OFF))
            stat_next.verr = 1'b1;
        stat_next.unused = 2'h0;
        if (wr_ctrl)
        begin
            ctrl_next        = cs3_ctrl_type'(reg_wdata_i);
            ctrl_next.unused = 1'b0;
        end
        if (slot_two_full_interface_i)
        begin
            ctrl_next.level = 1'b0;
            ctrl_next.halt  = 1'b1;
        end
        rdata_next = rdata_reg;
        if (reg_rd_i)
            rdata_next = (reg_addr_i == ADDR_STATUS) ? stat_reg : ctrl_reg;
        attn_next = (stat_reg.irq || stat_reg.atr || stat_reg.verr)
                    && !slot_two_full_interface_i;
    end

    // reset pin and answer timeout sequence
    always_comb
    begin
        seq_next = seq_reg;
        cnt_next = cnt_reg;
        atr_ovf  = 1'b0;
        case (seq_reg)
            SEQ_IDLE:
            begin
                cnt_next = '0;
                if (ctrl_reg.reset_ctl)
                    seq_next = ctrl_reg.art ? SEQ_DELAY : SEQ_WAIT;
            end
            SEQ_DELAY:
            begin
                if (card_rise)
                    cnt_next = cnt_reg + CNT_W'(1);
                if (!ctrl_reg.art || (card_rise && (cnt_reg == CNT_W'(RST_DELAY - 1))))
                begin
                    seq_next = SEQ_WAIT;
                    cnt_next = '0;
                end
            end
            SEQ_WAIT:
            begin
                if (card_rise)
                    cnt_next = cnt_reg + CNT_W'(1);
                if (io_prev_reg && !io_s)
                    seq_next = SEQ_DONE;
                else if (card_rise && (cnt_reg == CNT_W'(ATR_CYCLES - 1)))
                begin
                    atr_ovf  = 1'b1;
                    seq_next = SEQ_DONE;
                end
            end
            SEQ_DONE:
                seq_next = SEQ_DONE;
            default:
                seq_next = SEQ_IDLE;
        endcase
        if (!ctrl_reg.reset_ctl)
            seq_next = SEQ_IDLE;
        // aux pin path relies on the control bit being left clear
        rst_pin_next = (seq_next == SEQ_WAIT) || (seq_next == SEQ_DONE) || aux_rst_s;
    end

    // register stage
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stat_reg    <= STAT_RESET;
            ctrl_reg    <= CTRL_RESET;
            rdata_reg   <= 8'h00;
            seq_reg     <= SEQ_IDLE;
            cnt_reg     <= '0;
            rst_pin_reg <= 1'b0;
            attn_reg    <= 1'b0;
            io_prev_reg <= 1'b0;
        end
        else
        begin
            stat_reg    <= stat_next;
            ctrl_reg    <= ctrl_next;
            rdata_reg   <= rdata_next;
            seq_reg     <= seq_next;
            cnt_reg     <= cnt_next;
            rst_pin_reg <= rst_pin_next;
            attn_reg    <= attn_next;
            io_prev_reg <= io_s;
        end
    end

    // glitch-free card clock
    cs3_clkgen u_clkgen (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .halt_i    (ctrl_reg.halt),
        .level_i   (ctrl_reg.level),
        .src_i     (ctrl_reg.src),
        .conv_s_i  (conv_s),
        .aux_s_i   (aux_clk_s),
        .pin_o     (card_clock_pin_o),
        .rise_o    (card_rise),
        .stopped_o ()
    );

    assign reg_rdata_o      = rdata_reg;
    assign card_reset_pin_o = rst_pin_reg;
    assign slot_attention_o = attn_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_irq_on_good;
        $rose(stat_reg.good) |-> stat_reg.irq;
    endproperty
    a_irq_on_good: assert property (p_irq_on_good) else $error("irq flag missing");

    property p_good_off;
        stat_reg.good |-> ($past(stat_reg.vsel) != VSEL_OFF) && $past(in_range_s);
    endproperty
    a_good_off: assert property (p_good_off) else $error("good without range");

    property p_atr_set;
        atr_ovf |=> stat_reg.atr;
    endproperty
    a_atr_set: assert property (p_atr_set) else $error("timeout flag missing");

    property p_read_clear;
        (rd_stat && !wr_stat && !atr_ovf) |=> !stat_reg.atr && (reg_rdata_o == $past(stat_reg));
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_range_err;
        (stat_reg.good && !in_range_s && stat_reg.vsel != VSEL_OFF) |=> stat_reg.verr;
    endproperty
    a_range_err: assert property (p_range_err) else $error("range error missing");

    property p_rst_direct;
        (!ctrl_reg.art && ctrl_reg.reset_ctl && seq_reg == SEQ_IDLE) |=> card_reset_pin_o;
    endproperty
    a_rst_direct: assert property (p_rst_direct) else $error("reset pin late");

    property p_rst_clear;
        (!ctrl_reg.reset_ctl && !aux_rst_s) |=> !card_reset_pin_o;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset pin not low");

    property p_full_mode;
        slot_two_full_interface_i |=> ctrl_reg.halt && !ctrl_reg.level && !slot_attention_o;
    endproperty
    a_full_mode: assert property (p_full_mode) else $error("full mode not applied");

endmodule

/* File: cs3_card_model.sv */
module cs3_card_model
#(
    parameter int ANSWER_RISES = 3
)(
    // card contacts
    input  wire logic card_clock_pin_i,
    input  wire logic card_reset_pin_i,
    output logic      card_io_line_o,
    // bench command: low makes the card stay silent
    input  wire logic answer_en_i
);
    timeunit 1ns;
    timeprecision 100ps;

    int rise_count;

    // card clock rises counted only while the card is out of reset
    initial rise_count = 0;
    always @(posedge card_clock_pin_i or negedge card_reset_pin_i)
    begin
        if (!card_reset_pin_i)
            rise_count <= 0;
        else
            rise_count <= rise_count + 1;
    end

    // io rests at the pull-up level; the answer start bit holds it low two rises
    assign card_io_line_o = !(answer_en_i && card_reset_pin_i &&
        rise_count >= ANSWER_RISES && rise_count < ANSWER_RISES + 2);
endmodule

/* File: tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cs3_pkg::*;

    logic       clk;
    logic       arst_n;
    logic       reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       in_range;
    logic       full_mode;
    logic       conv_clk;
    logic       aux_clk;
    logic       aux_pin;
    logic       card_io;
    logic       card_clk;
    logic       card_rst;
    logic       attention;
    logic       answer_en;
    int         div_cnt;
    int         bad_count;
    int         compares;

    cs3_slot3 #(.ATR_CYCLES(8), .RST_DELAY(2)) dut (
        .clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .slot_regulator_in_range_i(in_range), .slot_two_full_interface_i(full_mode),
        .converter_clock_i(conv_clk), .auxiliary_clock_input_i(aux_clk),
        .auxiliary_input_pin_i(aux_pin), .card_io_line_i(card_io),
        .card_clock_pin_o(card_clk), .card_reset_pin_o(card_rst),
        .slot_attention_o(attention));

    cs3_card_model card (
        .card_clock_pin_i(card_clk), .card_reset_pin_i(card_rst),
        .card_io_line_o(card_io), .answer_en_i(answer_en));

    // master clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // converter edge every 4 cycles, auxiliary clock edge every 5
    always @(negedge clk)
    begin
        div_cnt <= div_cnt + 1;
        if (div_cnt % 4 == 3) conv_clk <= ~conv_clk;
        if (div_cnt % 5 == 4) aux_clk <= ~aux_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // read answer is registered, so it is settled at the following falling edge
    task automatic rdchk(input logic a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
    endtask

    task automatic count_toggles(input int w, output int t);
        logic last;
        t = 0;
        last = card_clk;
        repeat (w)
        begin
            @(negedge clk);
            if (card_clk !== last) t++;
            last = card_clk;
        end
    endtask

    task automatic t_reset_values();
        chk({5'h00, card_clk, card_rst, attention}, 8'h00);
        rdchk(ADDR_STATUS, 8'h00);
        rdchk(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h48);
        rdchk(ADDR_CTRL, 8'h08);
    endtask

    task automatic t_soft_set();
        wr(ADDR_STATUS, 8'h24);
        rdchk(ADDR_STATUS, 8'h24);
        rdchk(ADDR_STATUS, 8'h00);
        wr(ADDR_STATUS, 8'hDB);
        rdchk(ADDR_STATUS, 8'h03);
        wr(ADDR_STATUS, 8'h00);
    endtask

    // stop, switch while stopped, run, then count half periods over 80 cycles
    // source 0 stands for a master of 24 MHz or less; the model has no speed limit
    task automatic t_clock_sources();
        int exp_t [8] = '{80, 20, 10, 5, 16, 8, 40, 20};
        int t;
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_CTRL, 8'h08 | 8'((i + 7) % 8));
            wait_clk(40);
            wr(ADDR_CTRL, 8'h08 | 8'(i));
            wr(ADDR_CTRL, 8'(i));
            wait_clk(40);
            count_toggles(80, t);
            chk({7'h0, t >= exp_t[i] - 1 && t <= exp_t[i] + 1}, 8'h01);
        end
    endtask

    task automatic t_halt();
        int t;
        wr(ADDR_CTRL, 8'h1F);
        wait_clk(20);
        count_toggles(8, t);
        chk({card_clk, 7'(t)}, 8'h80);
        wr(ADDR_CTRL, 8'h0F);
        wait_clk(3);
        chk({7'h0, card_clk}, 8'h00);
    endtask

    task automatic t_reset_pin();
        wr(ADDR_CTRL, 8'h2F);
        chk({7'h0, card_rst}, 8'h00);
        wait_clk(1);
        chk({7'h0, card_rst}, 8'h01);
        wr(ADDR_CTRL, 8'h0F);
        // control bit lands one edge after the write, the pin one edge later
        wait_clk(1);
        chk({7'h0, card_rst}, 8'h00);
        aux_pin = 1'b1;
        wait_clk(4);
        chk({7'h0, card_rst}, 8'h01);
        aux_pin = 1'b0;
        wait_clk(4);
    endtask

    task automatic atr_run(input logic answer, input logic [7:0] exp);
        int n;
        wr(ADDR_CTRL, 8'h06);
        answer_en = answer;
        wr(ADDR_CTRL, 8'hA6);
        chk({7'h0, card_rst}, 8'h00);
        n = 0;
        while (card_rst !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, card_rst}, 8'h01);
        wait_clk(80);
        chk({7'h0, attention}, {7'h0, exp[5]});
        rdchk(ADDR_STATUS, exp);
    endtask

    task automatic t_answer_timeout();
        atr_run(1'b1, 8'h00);
        atr_run(1'b0, 8'h20);
        rdchk(ADDR_STATUS, 8'h00);
        wr(ADDR_CTRL, 8'h06);
    endtask

    task automatic t_full_mode();
        wr(ADDR_STATUS, 8'h20);
        wait_clk(2);
        chk({7'h0, attention}, 8'h01);
        full_mode = 1'b1;
        wait_clk(3);
        chk({7'h0, attention}, 8'h00);
        rdchk(ADDR_CTRL, 8'h0E);
        wr(ADDR_CTRL, 8'h16);
        rdchk(ADDR_CTRL, 8'h0E);
        full_mode = 1'b0;
        rdchk(ADDR_STATUS, 8'h20);
    endtask

    // card already held in reset before each supply change
    task automatic t_voltage();
        for (int c = 1; c < 4; c++)
        begin
            wr(ADDR_STATUS, 8'(c));
            in_range = 1'b1;
            wait_clk(6);
            rdchk(ADDR_STATUS, 8'hC0 | 8'(c));
            rdchk(ADDR_STATUS, 8'h40 | 8'(c));
            in_range = 1'b0;
            wait_clk(6);
            rdchk(ADDR_STATUS, 8'h04 | 8'(c));
            rdchk(ADDR_STATUS, 8'(c));
        end
        wr(ADDR_STATUS, 8'h00);
        in_range = 1'b1;
        wait_clk(6);
        rdchk(ADDR_STATUS, 8'h00);
    endtask

    // main sequence
    initial
    begin
        {arst_n, reg_addr, reg_wr, reg_rd, in_range, full_mode, aux_pin} = '0;
        {conv_clk, aux_clk, reg_wdata} = '0;
        {div_cnt, bad_count, compares} = '0;
        answer_en = 1'b1;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        t_reset_values();
        t_soft_set();
        t_clock_sources();
        t_halt();
        t_reset_pin();
        t_answer_timeout();
        t_full_mode();
        t_voltage();
        complete_run();
    end

    // watchdog well beyond the expected run of about 1700 cycles
    initial
    begin
        #60000;
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
